//--- emb_pkg.sv
// How it works
// - Read/write mode: write data, strobe, address registers advance on write tick.
// - Read/write mode: read strobe, address, output registers advance on read tick.
// - Read and write sides have their own clock enable and clear.
// - Input/output mode: every input register advances on the input tick.
// - Input/output mode: only output data register uses output tick and enable.
// - Every port register clears from local, global or chip-wide reset.
// - Single-port mode shares one address between reads and writes.
// - CAM compares the key against all words at once, returns match address.
// - Match flag is high when any stored word matches the key.
// - CAM holds 32 words of 32 bits each.
// - Don't-care bits written with a word are ignored in comparison.
// - Encoded output gives the binary index of the matching word.
// - Unencoded output shows match lines on 16 outputs over two cycles.
// - CAM write takes two cycles, three with don't-care bits.
// - Contents load at configuration and are writable during operation.
// - Five input port registers can be bypassed independently; the output register stays, its bypass bit only makes it load every cycle.
// - ROM mode: configuration-loaded pattern read back as a lookup table.
// - An unused block is powered down and stays idle.
// - RAM shapes 128x16, 256x8, 512x4, 1024x2, 2048x1.
// - Internal write pulse comes from registered strobe and write tick.
package emb_pkg;
  localparam int ADDR_W    = 11;
  localparam int RAM_BITS  = 16;
  localparam int RAM_ROWS  = 128;
  localparam int ROW_W     = 7;
  localparam int CAM_WORDS = 32;
  localparam int CAM_BITS  = 32;
  localparam int CAM_AW    = 5;
  localparam int HALF_W    = 16;
  // Block modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_RW  = 3'h1;
  localparam logic [2:0] MODE_IO  = 3'h2;
  localparam logic [2:0] MODE_SP  = 3'h3;
  localparam logic [2:0] MODE_ROM = 3'h4;
  localparam logic [2:0] MODE_CAM = 3'h5;
  // Bypass bit positions
  localparam int BP_WDATA = 0;
  localparam int BP_DOUT  = 1;
  localparam int BP_RADDR = 2;
  localparam int BP_WADDR = 3;
  localparam int BP_WSTB  = 4;
  localparam int BP_RSTB  = 5;
  // Reset values
  localparam logic [15:0] DOUT_RST = 16'h0000;
  // CAM write sequencer
  typedef enum logic [1:0] {
    EMB_CW_IDLE = 2'b00,
    EMB_CW_ONE  = 2'b01,
    EMB_CW_TWO  = 2'b11,
    EMB_CW_CARE = 2'b10
  } emb_cw_t;
endpackage : emb_pkg

//--- emb_block.sv
`timescale 1ns/1ps
`default_nettype none
module emb_block (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  mode,
  input  wire logic [2:0]  width_sel,
  input  wire logic [5:0]  bypass,
  input  wire logic        enc_sel,
  input  wire logic        clr_glob,
  input  wire logic        wr_tick,
  input  wire logic        wr_ce,
  input  wire logic        wr_clr,
  input  wire logic        rd_tick,
  input  wire logic        rd_ce,
  input  wire logic        rd_clr,
  input  wire logic        wr_en,
  input  wire logic [10:0] wr_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        mem_read_strobe,
  input  wire logic [10:0] rd_addr,
  input  wire logic        cfg_we,
  input  wire logic [6:0]  cfg_addr,
  input  wire logic [31:0] cfg_data,
  input  wire logic [31:0] cfg_care,
  input  wire logic        cam_wr,
  input  wire logic        cam_care_wr,
  input  wire logic [4:0]  cam_waddr,
  input  wire logic [31:0] cam_wdata,
  input  wire logic [31:0] cam_wcare,
  input  wire logic        cam_search,
  input  wire logic [31:0] cam_key,
  output logic [15:0]      rd_data,
  output logic             cam_busy,
  output logic             match_flag,
  output logic [4:0]       match_addr,
  output logic [15:0]      match_lines,
  output logic             match_upper,
  output logic             pwr_down
);
  logic [15:0] wd_r, wd_nxt;
  logic [10:0] wa_r, wa_nxt;
  logic [10:0] ra_r, ra_nxt;
  logic        ws_r, ws_nxt;
  logic        rs_r, rs_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic [15:0] mem_r [emb_pkg::RAM_ROWS];
  logic [15:0] mem_nxt [emb_pkg::RAM_ROWS];
  logic [31:0] cam_r [emb_pkg::CAM_WORDS];
  logic [31:0] cam_nxt [emb_pkg::CAM_WORDS];
  logic [31:0] care_r [emb_pkg::CAM_WORDS];
  logic [31:0] care_nxt [emb_pkg::CAM_WORDS];
  emb_pkg::emb_cw_t cw_r, cw_nxt;
  logic [4:0]  cwa_r, cwa_nxt;
  logic [31:0] cwd_r, cwd_nxt;
  logic [31:0] cwc_r, cwc_nxt;
  logic        cwm_r, cwm_nxt, busy_r, busy_nxt;
  logic [31:0] hits;
  logic [15:0] hi_r, hi_nxt;
  logic        flag_r, flag_nxt;
  logic [4:0]  maddr_r, maddr_nxt;
  logic [15:0] lines_r, lines_nxt;
  logic        upper_r, upper_nxt;
  logic        pd_r;
  logic        on;
  logic        in_w, in_r, out_en;
  logic        wclr, rclr;
  logic [15:0] wd_e;
  logic [10:0] wa_e, ra_e;
  logic        ws_e, rs_e;
  logic [6:0]  wrow, rrow;
  logic [3:0]  wsh, rsh;
  logic [15:0] lmask;
  logic        ram_ok;

  // Enables and clears per side
  always_comb begin
    on = (mode != emb_pkg::MODE_OFF) && (mode != emb_pkg::MODE_CAM);
    wclr = rst | clr_glob | wr_clr;
    rclr = rst | clr_glob | rd_clr;
    in_w = on & wr_tick & wr_ce;
    if (mode == emb_pkg::MODE_RW) begin
      in_r = on & rd_tick & rd_ce;
    end else begin
      in_r = in_w;
    end
    out_en = on & rd_tick & rd_ce;
    ram_ok = (mode != emb_pkg::MODE_ROM);
  end

  // Bypass selection of each input port register
  always_comb begin
    wd_e = bypass[emb_pkg::BP_WDATA] ? wr_data : wd_r;
    wa_e = bypass[emb_pkg::BP_WADDR] ? wr_addr : wa_r;
    ws_e = bypass[emb_pkg::BP_WSTB] ? wr_en : ws_r;
    rs_e = bypass[emb_pkg::BP_RSTB] ? mem_read_strobe : rs_r;
    if (mode == emb_pkg::MODE_SP) begin
      ra_e = wa_e;
    end else begin
      ra_e = bypass[emb_pkg::BP_RADDR] ? rd_addr : ra_r;
    end
  end

  // Word shape: row index and lane shift
  always_comb begin
    wrow = 7'h00;
    rrow = 7'h00;
    wsh = 4'h0;
    rsh = 4'h0;
    lmask = 16'hFFFF;
    unique case (width_sel)
      3'h1: begin
        wrow = wa_e[7:1]; rrow = ra_e[7:1];
        wsh = {wa_e[0], 3'h0}; rsh = {ra_e[0], 3'h0};
        lmask = 16'h00FF;
      end
      3'h2: begin
        wrow = wa_e[8:2]; rrow = ra_e[8:2];
        wsh = {wa_e[1:0], 2'h0}; rsh = {ra_e[1:0], 2'h0};
        lmask = 16'h000F;
      end
      3'h3: begin
        wrow = wa_e[9:3]; rrow = ra_e[9:3];
        wsh = {wa_e[2:0], 1'b0}; rsh = {ra_e[2:0], 1'b0};
        lmask = 16'h0003;
      end
      3'h4: begin
        wrow = wa_e[10:4]; rrow = ra_e[10:4];
        wsh = wa_e[3:0]; rsh = ra_e[3:0];
        lmask = 16'h0001;
      end
      default: begin
        wrow = wa_e[6:0]; rrow = ra_e[6:0];
      end
    endcase
  end

  // Port register next values
  always_comb begin
    wd_nxt = wd_r;
    wa_nxt = wa_r;
    ws_nxt = ws_r;
    ra_nxt = ra_r;
    rs_nxt = rs_r;
    dout_nxt = dout_r;
    if (in_w) begin
      wd_nxt = wr_data;
      wa_nxt = wr_addr;
      ws_nxt = wr_en & ram_ok;
    end
    if (in_r) begin
      ra_nxt = rd_addr;
      rs_nxt = mem_read_strobe;
    end
    // Array read sees pre-write contents
    if ((out_en | bypass[emb_pkg::BP_DOUT]) & rs_e & on) begin
      dout_nxt = (mem_r[rrow] >> rsh) & lmask;
    end
    if (wclr) begin
      wd_nxt = 16'h0000;
      wa_nxt = 11'h000;
      ws_nxt = 1'b0;
    end
    if (rclr) begin
      ra_nxt = 11'h000;
      rs_nxt = 1'b0;
      dout_nxt = emb_pkg::DOUT_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    wd_r <= wd_nxt;
    wa_r <= wa_nxt;
    ws_r <= ws_nxt;
    ra_r <= ra_nxt;
    rs_r <= rs_nxt;
    dout_r <= dout_nxt;
  end

  // Array writes: self-timed pulse and configuration load
  always_comb begin
    for (int i = 0; i < emb_pkg::RAM_ROWS; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (in_w & ws_e & ram_ok & ~wclr) begin
      mem_nxt[wrow] = (mem_r[wrow] & ~(lmask << wsh))
                    | ((wd_e & lmask) << wsh);
    end
    if (cfg_we) begin
      mem_nxt[cfg_addr] = cfg_data[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < emb_pkg::RAM_ROWS; i++) begin
      mem_r[i] <= mem_nxt[i];
    end
  end

  // Parallel compare of all CAM words
  always_comb begin
    for (int i = 0; i < emb_pkg::CAM_WORDS; i++) begin
      hits[i] = ~|((cam_r[i] ^ cam_key) & ~care_r[i]);
    end
  end

  // CAM write sequencer and search outputs
  always_comb begin
    cw_nxt = cw_r;
    cwa_nxt = cwa_r;
    cwd_nxt = cwd_r;
    cwc_nxt = cwc_r;
    cwm_nxt = cwm_r;
    for (int i = 0; i < emb_pkg::CAM_WORDS; i++) begin
      cam_nxt[i] = cam_r[i];
      care_nxt[i] = care_r[i];
    end
    flag_nxt = flag_r;
    maddr_nxt = maddr_r;
    lines_nxt = lines_r;
    upper_nxt = 1'b0;
    hi_nxt = hi_r;
    unique case (cw_r)
      emb_pkg::EMB_CW_IDLE: begin
        if (cam_wr && mode == emb_pkg::MODE_CAM) begin
          cwa_nxt = cam_waddr;
          cwd_nxt = cam_wdata;
          cwc_nxt = cam_care_wr ? cam_wcare : 32'h0000_0000;
          cwm_nxt = cam_care_wr;
          cw_nxt = emb_pkg::EMB_CW_ONE;
        end
      end
      emb_pkg::EMB_CW_ONE: begin
        cw_nxt = emb_pkg::EMB_CW_TWO;
      end
      emb_pkg::EMB_CW_TWO: begin
        cw_nxt = emb_pkg::EMB_CW_CARE;
        if (!cwm_r) begin
          cam_nxt[cwa_r] = cwd_r;
          care_nxt[cwa_r] = 32'h0000_0000;
          cw_nxt = emb_pkg::EMB_CW_IDLE;
        end
      end
      emb_pkg::EMB_CW_CARE: begin
        cam_nxt[cwa_r] = cwd_r;
        care_nxt[cwa_r] = cwc_r;
        cw_nxt = emb_pkg::EMB_CW_IDLE;
      end
    endcase
    if (cfg_we) begin
      cam_nxt[cfg_addr[4:0]] = cfg_data;
      care_nxt[cfg_addr[4:0]] = cfg_care;
    end
    if (upper_r == 1'b0 && cam_search && mode == emb_pkg::MODE_CAM) begin
      flag_nxt = |hits;
      maddr_nxt = 5'h00;
      for (int i = emb_pkg::CAM_WORDS - 1; i >= 0; i--) begin
        if (hits[i]) begin
          maddr_nxt = 5'(i);
        end
      end
      if (!enc_sel) begin
        lines_nxt = hits[15:0];
        hi_nxt = hits[31:16];
        upper_nxt = 1'b1;
      end
    end else if (upper_r) begin
      lines_nxt = hi_r;
    end
    if (rst) begin
      cw_nxt = emb_pkg::EMB_CW_IDLE;
      cwm_nxt = 1'b0;
      flag_nxt = 1'b0;
      maddr_nxt = 5'h00;
      lines_nxt = 16'h0000;
      upper_nxt = 1'b0;
      hi_nxt = 16'h0000;
      cwa_nxt = 5'h00;
      cwd_nxt = 32'h0000_0000;
      cwc_nxt = 32'h0000_0000;
    end
    // Busy flag registered so the output comes from a flop
    busy_nxt = (cw_nxt != emb_pkg::EMB_CW_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    cw_r <= cw_nxt;
    busy_r <= busy_nxt;
    cwa_r <= cwa_nxt;
    cwd_r <= cwd_nxt;
    cwc_r <= cwc_nxt;
    cwm_r <= cwm_nxt;
    hi_r <= hi_nxt;
    flag_r <= flag_nxt;
    maddr_r <= maddr_nxt;
    lines_r <= lines_nxt;
    upper_r <= upper_nxt;
    for (int i = 0; i < emb_pkg::CAM_WORDS; i++) begin
      cam_r[i] <= cam_nxt[i];
      care_r[i] <= care_nxt[i];
    end
  end

  // Power-down status
  always_ff @(posedge ref_clk) begin
    pd_r <= rst ? 1'b0 : (mode == emb_pkg::MODE_OFF);
  end

  assign rd_data = dout_r;
  assign cam_busy = busy_r;
  assign match_flag = flag_r;
  assign match_addr = maddr_r;
  assign match_lines = lines_r;
  assign match_upper = upper_r;
  assign pwr_down = pd_r;
endmodule // emb_block
`default_nettype wire

//--- emb_properties.sv
`timescale 1ns/1ps
`default_nettype none
module emb_properties (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [2:0]  mode,
  input wire logic        enc_sel,
  input wire logic        clr_glob,
  input wire logic        rd_clr,
  input wire logic        cam_wr,
  input wire logic        cam_care_wr,
  input wire logic        cam_search,
  input wire logic [15:0] rd_data,
  input wire logic        cam_busy,
  input wire logic        match_flag,
  input wire logic [4:0]  match_addr,
  input wire logic        match_upper,
  input wire logic        pwr_down
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Multi-step CAM responses
  sequence busy_two;
    cam_busy [*2] ##1 !cam_busy;
  endsequence
  sequence busy_three;
    cam_busy [*3] ##1 !cam_busy;
  endsequence
  sequence two_halves;
    match_upper ##1 !match_upper;
  endsequence
  logic cam_on;
  logic wr_go;
  logic srch;
  // Accepted CAM write and search
  assign cam_on = (mode == emb_pkg::MODE_CAM);
  assign wr_go  = cam_on && cam_wr && !cam_busy;
  assign srch   = cam_on && cam_search && !match_upper;
  AST_BUSY_TWO: assert property (wr_go && !cam_care_wr |=> busy_two)
    else $error("plain CAM write length wrong");
  AST_BUSY_THREE: assert property (wr_go && cam_care_wr |=> busy_three)
    else $error("masked CAM write length wrong");
  AST_HALVES: assert property (srch && !enc_sel |=> two_halves)
    else $error("match line halves out of order");
  AST_ENC_ONLY: assert property (srch && enc_sel |=> !match_upper [*2])
    else $error("upper half shown in encoded mode");
  AST_MATCH_HOLD: assert property (cam_on && !cam_search |=> $stable(match_flag) && $stable(match_addr))
    else $error("match result changed without search");
  AST_PWR: assert property (1'b1 |=> pwr_down == ($past(mode) == emb_pkg::MODE_OFF))
    else $error("power down does not follow mode");
  AST_RAM_IDLE: assert property ((cam_on || mode == emb_pkg::MODE_OFF) && !rd_clr && !clr_glob |=> $stable(rd_data))
    else $error("read data moved while RAM port idle");
  AST_OUT_CLR: assert property (rd_clr |=> rd_data == emb_pkg::DOUT_RST)
    else $error("read clear did not clear output");
endmodule // emb_properties
bind emb_block emb_properties i_emb_properties (.ref_clk, .rst, .mode, .enc_sel, .clr_glob,
  .rd_clr, .cam_wr, .cam_care_wr, .cam_search, .rd_data, .cam_busy, .match_flag,
  .match_addr, .match_upper, .pwr_down);
`default_nettype wire

//--- emb_user.sv
`timescale 1ns/1ps
`default_nettype none
module emb_user #(
  parameter int DIV = 1
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  output logic      tick
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  // Divider for one user clock domain
  always_comb begin
    cnt_nxt = (cnt_r == 4'(DIV - 1)) ? 4'h0 : cnt_r + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    cnt_r <= rst ? 4'h0 : cnt_nxt;
  end
  // One tick per divider period
  assign tick = (cnt_r == 4'(DIV - 1));
endmodule // emb_user
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic        wr;
    logic        care;
    logic [4:0]  wa;
    logic [31:0] wd;
    logic [31:0] wc;
    logic [31:0] key;
    logic        f;
    logic [4:0]  a;
    logic [15:0] lo;
    logic [15:0] hi;
  } emb_row_t;
  // Optional CAM write, then search key and expected answer
  emb_row_t rows [6] = '{
    '{1'b1, 1'b0, 5'h0c, 32'hFA12_0000, 32'h0, 32'hFA12_0000, 1'b1, 5'h0c, 16'h1000, 16'h0},
    '{1'b1, 1'b1, 5'h14, 32'h1234_5678, 32'hFF, 32'h1234_56AB, 1'b1, 5'h14, 16'h0, 16'h0010},
    '{1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 32'hDEAD_BEEF, 1'b0, 5'h00, 16'h0, 16'h0},
    '{1'b1, 1'b0, 5'h03, 32'hFA12_0000, 32'h0, 32'hFA12_0000, 1'b1, 5'h03, 16'h1008, 16'h0},
    '{1'b1, 1'b0, 5'h1f, 32'h0, 32'h0, 32'h0, 1'b1, 5'h1f, 16'h0, 16'h8000},
    '{1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 32'hA5A5_0000, 1'b1, 5'h00, 16'h0001, 16'h0}
  };
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  mode = 3'h0;
  logic [2:0]  width_sel = 3'h0;
  logic [5:0]  bypass = 6'h00;
  logic        enc_sel = 1'b0, clr_glob = 1'b0, wr_ce = 1'b1, wr_clr = 1'b0;
  logic        rd_ce = 1'b1, rd_clr = 1'b0, wr_en = 1'b0, mem_read_strobe = 1'b0;
  logic        cfg_we = 1'b0, cam_wr = 1'b0, cam_care_wr = 1'b0, cam_search = 1'b0;
  logic [10:0] wr_addr = 11'h000, rd_addr = 11'h000;
  logic [15:0] wr_data = 16'h0;
  logic [6:0]  cfg_addr = 7'h00;
  logic [31:0] cfg_data = 32'h0, cfg_care = 32'h0, cam_wdata = 32'h0, cam_wcare = 32'h0;
  logic [31:0] cam_key = 32'h0;
  logic [4:0]  cam_waddr = 5'h00;
  logic        wr_tick, rd_tick, cam_busy, match_flag, match_upper, pwr_down;
  logic [15:0] rd_data, match_lines;
  logic [4:0]  match_addr;
  int          fails = 0;
  int          checks_done = 0;
  int          i;
  // Clock and user-side tick makers
  always #2 ref_clk = ~ref_clk;
  emb_user #(.DIV(1)) i_emb_user (.ref_clk, .rst, .tick(wr_tick));
  emb_user #(.DIV(3)) i_emb_user_rd (.ref_clk, .rst, .tick(rd_tick));
  emb_block i_emb_block (
    .ref_clk, .rst, .mode, .width_sel, .bypass, .enc_sel, .clr_glob, .wr_tick, .wr_ce,
    .wr_clr, .rd_tick, .rd_ce, .rd_clr, .wr_en, .wr_addr, .wr_data, .mem_read_strobe,
    .rd_addr, .cfg_we, .cfg_addr, .cfg_data, .cfg_care, .cam_wr, .cam_care_wr, .cam_waddr,
    .cam_wdata, .cam_wcare, .cam_search, .cam_key, .rd_data, .cam_busy, .match_flag,
    .match_addr, .match_lines, .match_upper, .pwr_down
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // CAM word write, waits out the busy time
  task automatic cam_put(input logic c, input logic [4:0] a, input logic [31:0] d, m);
    int k;
    cam_wr <= 1'b1;
    cam_care_wr <= c;
    cam_waddr <= a;
    cam_wdata <= d;
    cam_wcare <= m;
    @(posedge ref_clk);
    cam_wr <= 1'b0;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (cam_busy !== 1'b0 && k < 8);
    if (k == 8) begin
      $display("MISMATCH %0t busy stuck", $time);
      fails++;
      summarize;
    end
    chk(k, c ? 32'h0000_0003 : 32'h0000_0002);
    @(posedge ref_clk);
  endtask
  // Search, then check the flag, and both halves of the answer when unencoded
  task automatic search(input logic [31:0] key, input logic f, input logic [4:0] a,
                        input logic [15:0] lo, hi);
    cam_key <= key;
    cam_search <= 1'b1;
    @(posedge ref_clk);
    cam_search <= 1'b0;
    #1;
    chk(match_flag, f);
    if (f) chk(match_addr, a);
    if (!enc_sel) chk(match_lines, lo);
    @(posedge ref_clk);
    #1;
    if (!enc_sel) chk(match_lines, hi);
    @(posedge ref_clk);
  endtask
  // Held read request, then one look at the output
  task automatic ram_rd(input logic [2:0] m, w, input logic [10:0] a, input logic [15:0] e, mk);
    mode <= m;
    width_sel <= w;
    mem_read_strobe <= 1'b1;
    rd_addr <= a;
    wr_addr <= a;
    repeat (7) @(posedge ref_clk);
    #1;
    chk(rd_data & mk, e);
    @(posedge ref_clk);
  endtask
  initial begin
    #100000;
    $display("MISMATCH %0t run too long", $time);
    fails++;
    summarize;
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(pwr_down, 1'b1);
    chk(cam_busy, 1'b0);
    chk(rd_data, emb_pkg::DOUT_RST);
    @(posedge ref_clk);
    mode <= emb_pkg::MODE_CAM;
    for (i = 0; i < 32; i++) begin
      cfg_we <= 1'b1;
      cfg_addr <= 7'(i);
      cfg_data <= {16'hA5A5, 16'(i)};
      @(posedge ref_clk);
    end
    cfg_we <= 1'b0;
    for (i = 0; i < 6; i++) begin
      if (rows[i].wr) cam_put(rows[i].care, rows[i].wa, rows[i].wd, rows[i].wc);
      search(rows[i].key, rows[i].f, rows[i].a, rows[i].lo, rows[i].hi);
    end
    cam_put(1'b0, 5'h03, 32'hA5A5_0003, 32'h0000_0000);
    enc_sel <= 1'b1;
    search(32'hFA12_0000, 1'b1, 5'h0c, 16'h0000, 16'h0000);
    enc_sel <= 1'b0;
    mode <= emb_pkg::MODE_RW;
    wr_en <= 1'b1;
    wr_addr <= 11'h005;
    wr_data <= 16'hBEEF;
    repeat (2) @(posedge ref_clk);
    wr_en <= 1'b0;
    ram_rd(emb_pkg::MODE_RW, 3'h0, 11'h005, 16'hBEEF, 16'hFFFF);
    chk(pwr_down, 1'b0);
    rd_ce <= 1'b0;
    ram_rd(emb_pkg::MODE_RW, 3'h0, 11'h007, 16'hBEEF, 16'hFFFF);
    rd_ce <= 1'b1;
    rd_clr <= 1'b1;
    @(posedge ref_clk);
    rd_clr <= 1'b0;
    #1;
    chk(rd_data, emb_pkg::DOUT_RST);
    @(posedge ref_clk);
    ram_rd(emb_pkg::MODE_IO, 3'h0, 11'h007, 16'h0007, 16'hFFFF);
    ram_rd(emb_pkg::MODE_SP, 3'h0, 11'h005, 16'hBEEF, 16'hFFFF);
    wr_en <= 1'b1;
    wr_data <= 16'h1234;
    ram_rd(emb_pkg::MODE_ROM, 3'h0, 11'h009, 16'h0009, 16'hFFFF);
    wr_en <= 1'b0;
    ram_rd(emb_pkg::MODE_RW, 3'h1, 11'h00B, 16'h00BE, 16'h00FF);
    ram_rd(emb_pkg::MODE_RW, 3'h4, 11'h055, 16'h0001, 16'h0001);
    // All six bypass bits set, output still registered: same-edge write and read of one row
    bypass <= 6'h3F;
    width_sel <= 3'h0;
    wr_en <= 1'b1;
    wr_addr <= 11'h006;
    wr_data <= 16'h1357;
    rd_addr <= 11'h006;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
    chk(rd_data, 16'h0006);
    @(posedge ref_clk);
    #1;
    chk(rd_data, 16'h1357);
    @(posedge ref_clk);
    summarize;
  end
endmodule // tb
`default_nettype wire
